// ===== hdl/bvr_adc_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "bvr_regs.svh"

module bvr_adc_ctl (
    input  wire logic       i_core_clk,       // core clock
    input  wire logic       i_rst_n,          // sync reset, active low
    input  wire logic       i_conv_bit,       // stored conversion control
    input  wire logic       i_fast_reset,     // external fast reset
    input  wire logic [7:0] i_adc_code,       // flash comparator code
    input  wire logic       i_chip_select,    // chip select
    input  wire logic       i_write_not_read, // 0 = read
    output logic            o_conv_phase,     // effective convert phase
    output logic [7:0]      o_data_lines,     // result to data lines
    output logic            o_data_lines_oe,  // data lines driven
    output logic            o_analog_route,   // pixel to analog out
    output logic            o_result_valid    // result held
);

    bvr_pkg::bvr_adc_state_type state_q;
    bvr_pkg::bvr_adc_state_type state_d;
    logic [7:0]                 result_q;
    logic                       phase;
    logic                       read_sel;

    assign phase    = i_conv_bit & ~i_fast_reset;
    assign read_sel = i_chip_select & ~i_write_not_read;

    always_comb begin
        state_d = state_q;
        case (state_q)
            bvr_pkg::ADC_RESET: begin
                if (phase) begin
                    state_d = bvr_pkg::ADC_CONVERT;
                end
            end
            bvr_pkg::ADC_CONVERT: begin
                state_d = phase ? bvr_pkg::ADC_DONE : bvr_pkg::ADC_RESET;
            end
            bvr_pkg::ADC_DONE: begin
                if (!phase) begin
                    state_d = bvr_pkg::ADC_RESET;
                end
            end
            default: begin
                state_d = bvr_pkg::ADC_RESET;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_q <= bvr_pkg::ADC_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // latch the code once, in the cycle after the convert edge
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            result_q <= 8'h00;
        end else if (state_q == bvr_pkg::ADC_CONVERT && phase) begin
            result_q <= i_adc_code;
        end
    end

    assign o_conv_phase    = phase;
    assign o_data_lines    = result_q;
    assign o_data_lines_oe = read_sel;
    assign o_analog_route  = read_sel;
    assign o_result_valid  = (state_q == bvr_pkg::ADC_DONE);

    property p_capture;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (state_q == bvr_pkg::ADC_CONVERT && phase)
            |=> (result_q == $past(i_adc_code) && o_result_valid);
    endproperty
    a_capture: assert property (p_capture)
        else $error("adc result not captured after convert");

    property p_fast_reset;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_fast_reset |=> (state_q == bvr_pkg::ADC_RESET);
    endproperty
    a_fast_reset: assert property (p_fast_reset)
        else $error("fast reset did not hold adc in reset");

    property p_conv_zero;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_conv_bit |-> (!o_conv_phase ##1 !o_result_valid);
    endproperty
    a_conv_zero: assert property (p_conv_zero)
        else $error("adc not in reset with control bit low");

    property p_read_drive;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_chip_select && !i_write_not_read)
            |-> (o_data_lines_oe && o_data_lines == result_q);
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("data lines not driven during read");

endmodule

`default_nettype wire

// ===== hdl/bvr_pkg.sv
package bvr_pkg;

    typedef enum logic [4:0] {
        CMD_NONE      = 5'h00,
        CMD_BIAS_A    = 5'h01,
        CMD_REF       = 5'h02,
        CMD_BIAS_B    = 5'h03,
        CMD_PIX_SUP   = 5'h04,
        CMD_OUT_BUF   = 5'h05,
        CMD_AMP_CONF  = 5'h06,
        CMD_AMP_OP    = 5'h07,
        CMD_MISC      = 5'h08,
        CMD_COL       = 5'h09,
        CMD_ADC_CTRL  = 5'h0A,
        CMD_LOW_REF   = 5'h0B,
        CMD_HIGH_REF  = 5'h0C,
        CMD_LATCH     = 5'h0D,
        CMD_ANALOG_EN = 5'h0E,
        CMD_KEY1      = 5'h0F,
        CMD_KEY2      = 5'h10,
        CMD_KEY3      = 5'h11,
        CMD_ROW       = 5'h12,
        CMD_HSW       = 5'h13,
        CMD_VSW       = 5'h14
    } bvr_cmd_type;

    typedef enum logic [1:0] {
        ADC_RESET   = 2'b00,
        ADC_CONVERT = 2'b01,
        ADC_DONE    = 2'b10
    } bvr_adc_state_type;

endpackage

// ===== hdl/bvr_readout.sv
// How it works
// - vault opens only while the three key registers hold 12, 21 and 22.
// - any non-key write to a key register locks the vault at once.
// - protected bias commands are dropped while the vault is locked.
// - vault status output is 1 when open, 0 when locked.
// - analog enable writes take effect only while the vault is open.
// - bias generators turn on only when argument low bits equal 010.
// - analog enable output is 0 enabled, 1 disabled; disabled after reset.
// - adc low/high reference and latch bias writes are accepted regardless of vault.
// - bias values may change while generators stay enabled.
// - conversion bit 0 low holds adc in reset, high starts conversion.
// - bit 2 high weakly pulls the low reference toward ground.
// - after conversion start a read returns the 8-bit unsigned pixel code.
// - fast reset input forces adc reset; release starts a conversion.
// - fast reset input is pulled down, inactive when undriven; i_fast_reset is a plain input here with no pull-down.
// - row and column indices 0..63 small array, 0..255 large.
// - any subset of rows and columns may be addressed.
// - selected read drives result on data lines, routes pixel out.
// - bias command is six-bit header plus six-bit argument.
`timescale 1ns/1ps
`default_nettype none
`include "bvr_regs.svh"

module bvr_readout (
    input  wire logic        i_core_clk,            // 100 MHz clock
    input  wire logic        i_rst_n,               // sync reset, low
    input  wire logic        i_cmd_valid,           // command strobe
    input  wire logic [11:0] i_cmd,                 // 12-bit command
    input  wire logic        i_chip_select,         // chip select
    input  wire logic        i_write_not_read,      // 0 = read
    input  wire logic        i_fast_adc_reset_input,// fast adc reset
    input  wire logic [7:0]  i_adc_code,            // flash comparators
    output logic             o_vault_open_status,   // 1 = unlocked
    output logic             o_analog_enable_n,     // 0 = enabled
    output logic [5:0]       o_protected_bias_a,    // vaulted bias
    output logic [5:0]       o_protected_bias_b,    // vaulted bias
    output logic [5:0]       o_reference_bias,      // vaulted bias
    output logic [5:0]       o_pixel_supply_bias,   // vaulted bias
    output logic [5:0]       o_output_buffer_bias,  // vaulted bias
    output logic [5:0]       o_adc_low_reference,   // open bias
    output logic [5:0]       o_adc_high_reference,  // open bias
    output logic [5:0]       o_latch_bias,          // open bias
    output logic [3:0]       o_amplifier_config,    // mid-amp config
    output logic [5:0]       o_amplifier_operation, // mid-amp switches
    output logic [4:0]       o_focal_flags,         // focal plane flags
    output logic [7:0]       o_row_select,          // row index
    output logic [7:0]       o_column_select,       // column index
    output logic [7:0]       o_horiz_bin,           // column switches
    output logic [7:0]       o_vert_bin,            // row switches
    output logic             o_conversion_control,  // adc phase
    output logic             o_legacy_adc_link,     // legacy bit
    output logic             o_low_ref_ground_short,// weak pull on ref
    output logic [7:0]       o_data_lines,          // read data
    output logic             o_data_lines_oe,       // data lines driven
    output logic             o_analog_route,        // pixel to pad
    output logic             o_result_valid         // result held
);

    function automatic bvr_pkg::bvr_cmd_type decode(input logic [11:0] c);
        logic [2:0] sub;
        sub = c[`BVR_SUB_HI:`BVR_SUB_LO];
        decode = bvr_pkg::CMD_NONE;
        case (c[`BVR_GRP_HI:`BVR_GRP_LO])
            `BVR_GRP_BIAS: begin
                case (sub)
                    `BVR_SUB_BIAS_A:   decode = bvr_pkg::CMD_BIAS_A;
                    `BVR_SUB_REF:      decode = bvr_pkg::CMD_REF;
                    `BVR_SUB_BIAS_B:   decode = bvr_pkg::CMD_BIAS_B;
                    `BVR_SUB_PIX_SUP:  decode = bvr_pkg::CMD_PIX_SUP;
                    `BVR_SUB_OUT_BUF:  decode = bvr_pkg::CMD_OUT_BUF;
                    `BVR_SUB_AMP_CONF: decode = bvr_pkg::CMD_AMP_CONF;
                    `BVR_SUB_AMP_OP:   decode = bvr_pkg::CMD_AMP_OP;
                    default:           decode = bvr_pkg::CMD_NONE;
                endcase
            end
            `BVR_GRP_ADC: begin
                case (sub)
                    `BVR_SUB_ADC_CTRL:  decode = bvr_pkg::CMD_ADC_CTRL;
                    `BVR_SUB_LOW_REF:   decode = bvr_pkg::CMD_LOW_REF;
                    `BVR_SUB_HIGH_REF:  decode = bvr_pkg::CMD_HIGH_REF;
                    `BVR_SUB_LATCH:     decode = bvr_pkg::CMD_LATCH;
                    `BVR_SUB_ANALOG_EN: decode = bvr_pkg::CMD_ANALOG_EN;
                    `BVR_SUB_KEY1:      decode = bvr_pkg::CMD_KEY1;
                    `BVR_SUB_KEY2:      decode = bvr_pkg::CMD_KEY2;
                    `BVR_SUB_KEY3:      decode = bvr_pkg::CMD_KEY3;
                    default:            decode = bvr_pkg::CMD_NONE;
                endcase
            end
            `BVR_GRP_MISC: decode = bvr_pkg::CMD_MISC;
            `BVR_GRP_COL:  decode = bvr_pkg::CMD_COL;
            `BVR_GRP_ROW:  decode = bvr_pkg::CMD_ROW;
            `BVR_GRP_HSW:  decode = bvr_pkg::CMD_HSW;
            `BVR_GRP_VSW:  decode = bvr_pkg::CMD_VSW;
            default:       decode = bvr_pkg::CMD_NONE;
        endcase
    endfunction

    bvr_pkg::bvr_cmd_type cmd;
    logic [5:0]           arg;
    logic [7:0]           idx;
    logic [5:0]           key_q [3];
    logic                 vault_open;
    logic                 prot_ok;
    logic                 analog_on_q;
    logic [5:0]           prot_q [5];
    logic [5:0]           low_ref_q;
    logic [5:0]           high_ref_q;
    logic [5:0]           latch_q;
    logic [2:0]           adc_ctrl_q;
    logic [3:0]           amp_conf_q;
    logic [5:0]           amp_op_q;
    logic [4:0]           flags_q;
    logic [7:0]           row_q;
    logic [7:0]           col_q;
    logic [7:0]           hsw_q;
    logic [7:0]           vsw_q;

    assign cmd = i_cmd_valid ? decode(i_cmd) : bvr_pkg::CMD_NONE;
    assign arg = i_cmd[`BVR_ARG_HI:`BVR_ARG_LO];
    assign idx = i_cmd[7:0];

    // the vault is a pure function of the stored keys
    assign vault_open = key_q[0] == `BVR_KEY_FIRST
                     && key_q[1] == `BVR_KEY_SECOND
                     && key_q[2] == `BVR_KEY_THIRD;
    assign prot_ok    = vault_open;

    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_key
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    key_q[k] <= `BVR_KEY_RST;
                end else if (cmd == bvr_pkg::bvr_cmd_type'(
                             5'(bvr_pkg::CMD_KEY1) + 5'(k))) begin
                    key_q[k] <= arg;
                end
            end
        end
        // protected biases in order a, reference, b, supply, buffer
        for (k = 0; k < 5; k++) begin : g_prot
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    prot_q[k] <= `BVR_BIAS_RST;
                end else if (prot_ok && cmd == bvr_pkg::bvr_cmd_type'(
                             5'(bvr_pkg::CMD_BIAS_A) + 5'(k))) begin
                    prot_q[k] <= arg;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            analog_on_q <= 1'b0;
        end else if (prot_ok && cmd == bvr_pkg::CMD_ANALOG_EN) begin
            analog_on_q <= (arg[2:0] == `BVR_ANALOG_ON_CODE);
        end
    end

    // open biases take writes with the vault in any state
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            low_ref_q  <= `BVR_BIAS_RST;
            high_ref_q <= `BVR_BIAS_RST;
            latch_q    <= `BVR_BIAS_RST;
        end else begin
            if (cmd == bvr_pkg::CMD_LOW_REF) begin
                low_ref_q <= arg;
            end
            if (cmd == bvr_pkg::CMD_HIGH_REF) begin
                high_ref_q <= arg;
            end
            if (cmd == bvr_pkg::CMD_LATCH) begin
                latch_q <= arg;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            adc_ctrl_q <= `BVR_ADC_CTRL_RST;
        end else if (cmd == bvr_pkg::CMD_ADC_CTRL) begin
            adc_ctrl_q <= arg[2:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            amp_conf_q <= 4'h0;
            amp_op_q   <= 6'h00;
            flags_q    <= `BVR_FLAGS_RST;
            hsw_q      <= `BVR_SEL_RST;
            vsw_q      <= `BVR_SEL_RST;
        end else begin
            case (cmd)
                bvr_pkg::CMD_AMP_CONF: amp_conf_q <= arg[3:0];
                bvr_pkg::CMD_AMP_OP:   amp_op_q   <= arg;
                bvr_pkg::CMD_MISC:     flags_q    <= arg[4:0];
                bvr_pkg::CMD_HSW:      hsw_q      <= idx;
                bvr_pkg::CMD_VSW:      vsw_q      <= idx;
                default: begin
                end
            endcase
        end
    end

    // any index is taken; the small array ignores the upper bits
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            row_q <= `BVR_SEL_RST;
            col_q <= `BVR_SEL_RST;
        end else begin
            if (cmd == bvr_pkg::CMD_ROW) begin
                row_q <= idx;
            end
            if (cmd == bvr_pkg::CMD_COL) begin
                col_q <= idx;
            end
        end
    end

    bvr_adc_ctl u_adc (
        .i_core_clk       (i_core_clk),
        .i_rst_n          (i_rst_n),
        .i_conv_bit       (adc_ctrl_q[`BVR_ADC_CONV_BIT]),
        .i_fast_reset     (i_fast_adc_reset_input),
        .i_adc_code       (i_adc_code),
        .i_chip_select    (i_chip_select),
        .i_write_not_read (i_write_not_read),
        .o_conv_phase     (o_conversion_control),
        .o_data_lines     (o_data_lines),
        .o_data_lines_oe  (o_data_lines_oe),
        .o_analog_route   (o_analog_route),
        .o_result_valid   (o_result_valid)
    );

    assign o_vault_open_status    = vault_open;
    assign o_analog_enable_n      = ~analog_on_q;
    assign o_protected_bias_a     = prot_q[0];
    assign o_reference_bias       = prot_q[1];
    assign o_protected_bias_b     = prot_q[2];
    assign o_pixel_supply_bias    = prot_q[3];
    assign o_output_buffer_bias   = prot_q[4];
    assign o_adc_low_reference    = low_ref_q;
    assign o_adc_high_reference   = high_ref_q;
    assign o_latch_bias           = latch_q;
    assign o_amplifier_config     = amp_conf_q;
    assign o_amplifier_operation  = amp_op_q;
    assign o_focal_flags          = flags_q;
    assign o_row_select           = row_q;
    assign o_column_select        = col_q;
    assign o_horiz_bin            = hsw_q;
    assign o_vert_bin             = vsw_q;
    assign o_legacy_adc_link      = adc_ctrl_q[`BVR_ADC_LEGACY_BIT];
    assign o_low_ref_ground_short = adc_ctrl_q[`BVR_ADC_SHORT_BIT];

    sequence s_unlock;
        i_cmd_valid && decode(i_cmd) == bvr_pkg::CMD_KEY1
            && i_cmd[5:0] == 6'h0C ##1 !i_cmd_valid ##1
        i_cmd_valid && decode(i_cmd) == bvr_pkg::CMD_KEY2
            && i_cmd[5:0] == 6'h15 ##1 !i_cmd_valid ##1
        i_cmd_valid && decode(i_cmd) == bvr_pkg::CMD_KEY3
            && i_cmd[5:0] == 6'h16;
    endsequence

    property p_unlock;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_unlock |=> o_vault_open_status;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("vault did not open after three keys");

    property p_relock;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (cmd inside {bvr_pkg::CMD_KEY1, bvr_pkg::CMD_KEY2,
                     bvr_pkg::CMD_KEY3} && arg != 6'h0C
         && arg != 6'h15 && arg != 6'h16) |=> !o_vault_open_status;
    endproperty
    a_relock: assert property (p_relock)
        else $error("vault stayed open after non-key write");

    property p_locked_drop;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!o_vault_open_status && cmd == bvr_pkg::CMD_BIAS_A)
            |=> $stable(o_protected_bias_a);
    endproperty
    a_locked_drop: assert property (p_locked_drop)
        else $error("protected bias changed with vault locked");

    property p_enable_locked;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!o_vault_open_status && cmd == bvr_pkg::CMD_ANALOG_EN)
            |=> $stable(o_analog_enable_n);
    endproperty
    a_enable_locked: assert property (p_enable_locked)
        else $error("analog enable changed with vault locked");

    property p_enable_code;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_vault_open_status && cmd == bvr_pkg::CMD_ANALOG_EN)
            |=> (o_analog_enable_n == ($past(arg[2:0]) != 3'h2));
    endproperty
    a_enable_code: assert property (p_enable_code)
        else $error("analog enable ignores the 010 code");

    property p_open_write;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (cmd == bvr_pkg::CMD_LATCH) |=> (o_latch_bias == $past(arg));
    endproperty
    a_open_write: assert property (p_open_write)
        else $error("latch bias write lost");

    property p_reset_state;
        @(posedge i_core_clk)
        !i_rst_n |=> (!o_vault_open_status && o_analog_enable_n);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset did not lock vault and disable analog");

endmodule

`default_nettype wire

// ===== hdl/bvr_regs.svh
`ifndef BVR_REGS_SVH
`define BVR_REGS_SVH

// command field positions
`define BVR_GRP_HI          11
`define BVR_GRP_LO          9
`define BVR_SUB_HI          8
`define BVR_SUB_LO          6
`define BVR_ARG_HI          5
`define BVR_ARG_LO          0

// top three bits of a command
`define BVR_GRP_BIAS        3'h0
`define BVR_GRP_MISC        3'h1
`define BVR_GRP_COL         3'h2
`define BVR_GRP_ADC         3'h3
`define BVR_GRP_ROW         3'h4
`define BVR_GRP_HSW         3'h5
`define BVR_GRP_VSW         3'h6

// sub-header inside group 0
`define BVR_SUB_BIAS_A      3'h0
`define BVR_SUB_REF         3'h1
`define BVR_SUB_BIAS_B      3'h2
`define BVR_SUB_PIX_SUP     3'h3
`define BVR_SUB_OUT_BUF     3'h4
`define BVR_SUB_AMP_CONF    3'h6
`define BVR_SUB_AMP_OP      3'h7

// sub-header inside group 3
`define BVR_SUB_ADC_CTRL    3'h0
`define BVR_SUB_LOW_REF     3'h1
`define BVR_SUB_HIGH_REF    3'h2
`define BVR_SUB_LATCH       3'h3
`define BVR_SUB_ANALOG_EN   3'h4
`define BVR_SUB_KEY1        3'h5
`define BVR_SUB_KEY2        3'h6
`define BVR_SUB_KEY3        3'h7

// vault keys and analog enable code
`define BVR_KEY_FIRST       6'h0C
`define BVR_KEY_SECOND      6'h15
`define BVR_KEY_THIRD       6'h16
`define BVR_ANALOG_ON_CODE  3'h2

// adc control bit positions
`define BVR_ADC_CONV_BIT    0
`define BVR_ADC_LEGACY_BIT  1
`define BVR_ADC_SHORT_BIT   2

// reset values
`define BVR_KEY_RST         6'h00
`define BVR_BIAS_RST        6'h00
`define BVR_ADC_CTRL_RST    3'h0
`define BVR_SEL_RST         8'h00
`define BVR_FLAGS_RST       5'h00

`endif

// ===== sim/bias_vault_adc_pixel_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none

module bias_vault_adc_pixel_readout_tb;
    logic       i_core_clk, i_rst_n, i_cmd_valid, i_chip_select;
    logic       i_write_not_read, i_fast_adc_reset_input;
    logic [11:0] i_cmd;
    logic [7:0] i_adc_code, o_data_lines, v;
    logic       o_vault_open_status, o_analog_enable_n, o_conversion_control;
    logic       o_legacy_adc_link, o_low_ref_ground_short, o_data_lines_oe;
    logic       o_analog_route, o_result_valid;
    logic [5:0] o_protected_bias_a, o_protected_bias_b, o_reference_bias;
    logic [5:0] o_pixel_supply_bias, o_output_buffer_bias, o_latch_bias;
    logic [5:0] o_adc_low_reference, o_adc_high_reference;
    logic [5:0] o_amplifier_operation, bv[5];
    logic [3:0] o_amplifier_config;
    logic [4:0] o_focal_flags;
    logic [7:0] o_row_select, o_column_select, o_horiz_bin, o_vert_bin;
    logic [7:0] exp_q[$];
    int         fails, check_count, cycles;

    bvr_readout dut_u (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cmd(i_cmd),
        .i_cmd_valid(i_cmd_valid), .i_chip_select(i_chip_select),
        .i_write_not_read(i_write_not_read), .i_adc_code(i_adc_code),
        .i_fast_adc_reset_input(i_fast_adc_reset_input),
        .o_vault_open_status(o_vault_open_status),
        .o_analog_enable_n(o_analog_enable_n),
        .o_protected_bias_a(o_protected_bias_a),
        .o_protected_bias_b(o_protected_bias_b),
        .o_reference_bias(o_reference_bias),
        .o_pixel_supply_bias(o_pixel_supply_bias),
        .o_output_buffer_bias(o_output_buffer_bias),
        .o_adc_low_reference(o_adc_low_reference),
        .o_adc_high_reference(o_adc_high_reference),
        .o_latch_bias(o_latch_bias), .o_focal_flags(o_focal_flags),
        .o_amplifier_config(o_amplifier_config),
        .o_amplifier_operation(o_amplifier_operation),
        .o_row_select(o_row_select), .o_column_select(o_column_select),
        .o_horiz_bin(o_horiz_bin), .o_vert_bin(o_vert_bin),
        .o_conversion_control(o_conversion_control),
        .o_legacy_adc_link(o_legacy_adc_link),
        .o_low_ref_ground_short(o_low_ref_ground_short),
        .o_data_lines(o_data_lines), .o_data_lines_oe(o_data_lines_oe),
        .o_analog_route(o_analog_route), .o_result_valid(o_result_valid));
    bvr_host_model host_u (.i_core_clk(i_core_clk), .o_cmd_valid(i_cmd_valid),
        .o_cmd(i_cmd), .o_chip_select(i_chip_select),
        .o_write_not_read(i_write_not_read));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    task automatic wrap_up;
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // waits for a held result, notes the current adc input code, then reads it back
    task automatic rd;
        for (int k = 0; k < 8 && o_result_valid !== 1'b1; k++) @(negedge i_core_clk);
        chk("result_valid", 8'h01, o_result_valid);
        exp_q.push_back(i_adc_code);
        host_u.receive(1'b0);
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
        if (o_data_lines_oe === 1'b1) begin
            chk("analog_route", 8'h01, o_analog_route);
            if (exp_q.size() == 0) chk("data_lines_oe", 8'h00, 8'h01);
            else chk("data_lines", exp_q.pop_front(), o_data_lines);
        end
    end

    initial begin
        i_rst_n = 1'b0;
        i_fast_adc_reset_input = 1'b0;
        i_adc_code = 8'h00;
        fails = 0;
        check_count = 0;
        cycles = 0;
        void'($urandom(32'h63bf));
        repeat (3) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        chk("vault", 8'h00, o_vault_open_status);
        chk("analog_en_n", 8'h01, o_analog_enable_n);
        host_u.send(12'h03F);
        host_u.send(12'h702);
        host_u.send(12'h67F);
        host_u.send(12'h6F3);
        host_u.send(12'h6AA);
        chk("bias_a", 8'h00, o_protected_bias_a);
        chk("analog_en_n", 8'h01, o_analog_enable_n);
        chk("low_ref", 8'h3F, o_adc_low_reference);
        chk("latch", 8'h33, o_latch_bias);
        chk("high_ref", 8'h2A, o_adc_high_reference);
        host_u.send(12'h74C);
        host_u.send(12'h795);
        chk("vault", 8'h00, o_vault_open_status);
        host_u.send(12'h7D6);
        chk("vault", 8'h01, o_vault_open_status);
        host_u.send(12'h794);
        chk("vault", 8'h00, o_vault_open_status);
        host_u.send(12'h795);
        foreach (bv[k]) begin
            bv[k] = 6'($urandom_range(63));
            host_u.send({3'h0, 3'(k), bv[k]});
        end
        chk("bias_a", bv[0], o_protected_bias_a);
        chk("ref", bv[1], o_reference_bias);
        chk("bias_b", bv[2], o_protected_bias_b);
        chk("pix_sup", bv[3], o_pixel_supply_bias);
        chk("out_buf", bv[4], o_output_buffer_bias);
        for (int k = 0; k < 8; k++) begin
            host_u.send({6'h1C, 3'($urandom), 3'(k)});
            chk("analog_en_n", 8'(k != 2), o_analog_enable_n);
        end
        host_u.send(12'h702);
        host_u.send(12'h005);
        chk("analog_en_n", 8'h00, o_analog_enable_n);
        chk("bias_a", 8'h05, o_protected_bias_a);
        host_u.send(12'h207);
        host_u.send(12'h18C);
        host_u.send(12'h1C1);
        chk("focal", 8'h07, o_focal_flags);
        chk("amp_conf", 8'h0C, o_amplifier_config);
        chk("amp_op", 8'h01, o_amplifier_operation);
        host_u.send(12'h740);
        host_u.send(12'h03F);
        host_u.send(12'h700);
        chk("vault", 8'h00, o_vault_open_status);
        chk("bias_a", 8'h05, o_protected_bias_a);
        chk("analog_en_n", 8'h00, o_analog_enable_n);
        repeat (3) begin
            v = 8'($urandom);
            host_u.send({4'h8, v});
            repeat (300) @(negedge i_core_clk);
            host_u.send({4'h4, ~v});
            host_u.send({4'hA, v});
            host_u.send({4'hC, ~v});
            chk("row", v, o_row_select);
            chk("col", ~v, o_column_select);
            chk("hsw", v, o_horiz_bin);
            chk("vsw", ~v, o_vert_bin);
        end
        host_u.send(12'hA00);
        host_u.send(12'hC00);
        chk("hsw", 8'h00, o_horiz_bin);
        chk("vsw", 8'h00, o_vert_bin);
        for (int k = 0; k < 8; k++) begin
            if (k[1] == 1'b0) begin
                host_u.send(12'h600 + 12'(k));
                chk("conv", 8'(k[0]), o_conversion_control);
                chk("short", 8'(k[2]), o_low_ref_ground_short);
                chk("legacy", 8'h00, o_legacy_adc_link);
            end
        end
        host_u.send(12'h600);
        i_adc_code = 8'($urandom);
        host_u.send(12'h601);
        repeat (20) @(negedge i_core_clk);
        rd();
        i_fast_adc_reset_input = 1'b1;
        i_adc_code = ~i_adc_code;
        @(negedge i_core_clk);
        chk("conv", 8'h00, o_conversion_control);
        @(negedge i_core_clk);
        i_fast_adc_reset_input = 1'b0;
        rd();
        host_u.receive(1'b1);
        repeat (2) @(negedge i_core_clk);
        wrap_up();
    end
endmodule

`default_nettype wire

// ===== sim/bvr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module bvr_host_model (
    input  wire logic   i_core_clk,       // core clock
    output logic        o_cmd_valid,      // command strobe
    output logic [11:0] o_cmd,            // command word
    output logic        o_chip_select,    // chip select
    output logic        o_write_not_read  // 0 = read
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = 12'h000;
        o_chip_select = 1'b0;
        o_write_not_read = 1'b1;
    end

    task automatic send(input logic [11:0] c);
        @(negedge i_core_clk);
        o_cmd_valid = 1'b1;
        o_cmd = c;
        @(negedge i_core_clk);
        o_cmd_valid = 1'b0;
        o_cmd = ~c; // released word never shows the old value
    endtask

    task automatic receive(input logic write_not_read);
        @(negedge i_core_clk);
        o_write_not_read = write_not_read;
        o_chip_select = 1'b1;
        @(negedge i_core_clk);
        o_chip_select = 1'b0;
        o_write_not_read = 1'b1;
    endtask
endmodule

`default_nettype wire
